// *** epc_pkg.sv ***
// Operation
// - Subcommand code 2h in parameter low nibble selects timer setting.
// - Subcommand code 3h in parameter low nibble selects state setting.
// - Condition identifier register picks the condition all updates apply to.
// - Successful timer subcommand loads the timer into the current setting.
// - Timer subcommand with enable set enables only for a non-zero timer.
// - Timer subcommand with enable clear disables the current timer.
// - Timer subcommand with save on savable condition copies timer and enable.
// - Parameter bit 7 picks timer units, 100 ms or 1 minute.
// - Parameter bit 5 requests enable, bit 4 requests save.
// - Timer above the maximum is replaced by the maximum.
// - Timer below the minimum is replaced by the minimum.
// - Maximum is 3BFFC4h in 100 ms units, minimum is zero.
// - Timer subcommand aborts while the power condition feature is off.
// - Timer subcommand aborts for unsupported or unchangeable conditions.
// - Timer subcommand aborts when save targets an unsavable condition.
// - Timer subcommand never aborts for its timer value; it clamps it instead.
// - An abort leaves all current and saved settings unchanged.
// - State subcommand enables the current timer per the enable bit.
// - State subcommand with save copies only the enable flag to saved.
// - State subcommand aborts on the same condition and feature checks.
package epc_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_FEAT_ERR = 4'h0;
   localparam logic [3:0] OFS_COND_ID = 4'h1;
   localparam logic [3:0] OFS_PARAMS = 4'h2;
   localparam logic [3:0] OFS_TMR_LO = 4'h3;
   localparam logic [3:0] OFS_TMR_HI = 4'h4;
   localparam logic [3:0] OFS_DRV_SEL = 4'h5;
   localparam logic [3:0] OFS_CMD_STAT = 4'h6;
   localparam logic [3:0] OFS_EPC_CTRL = 4'h7;
   localparam logic [3:0] OFS_SUP_MASK = 4'h8;
   localparam logic [3:0] OFS_CHG_MASK = 4'h9;
   localparam logic [3:0] OFS_SAV_MASK = 4'ha;
   localparam logic [3:0] OFS_VIEW_SEL = 4'hb;
   localparam logic [3:0] OFS_VIEW_CUR = 4'hc;
   localparam logic [3:0] OFS_VIEW_SAV = 4'hd;

   // ****************************************
   // Codes and fields
   // ****************************************
   localparam logic [7:0] OPC_SET_FEAT = 8'hef;
   localparam logic [7:0] FEAT_EPC = 8'h4a;
   localparam logic [3:0] SUB_TIMER = 4'h2;
   localparam logic [3:0] SUB_STATE = 4'h3;
   localparam int PRM_UNITS = 7;
   localparam int PRM_ENABLE = 5;
   localparam int PRM_SAVE = 4;
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DF = 5;
   localparam int ST_ERR = 0;
   localparam int ER_ABT = 2;
   localparam int TMR_W = 22;
   localparam logic [21:0] TMR_MAX = 22'h3bffc4;
   localparam logic [21:0] TMR_MIN = 22'h000000;
   localparam logic [9:0] TICKS_PER_MIN = 10'h258;
   localparam logic EPC_EN_RST = 1'b1;
   localparam logic [7:0] MASK_RST = 8'hff;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic en;
      logic [21:0] tmr;
   } cond_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } state_t;

endpackage

// *** epc_cmd.sv ***
`timescale 1ns/1ps
`default_nettype none
module epc_cmd #(
   parameter int NUM_COND = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire epc_pkg::reg_req_t req,
   output logic [31:0] rdata,
   output logic cmd_done
);
   import epc_pkg::*;

   localparam int IDX_W = $clog2(NUM_COND);

   if (NUM_COND < 2 || NUM_COND > 8) begin
      $error("NUM_COND must lie between 2 and 8.");
   end

   // ****************************************
   // Timer conversion
   // ****************************************
   // Minute units are scaled to 100 ms ticks before clamping, so one
   // limit serves both units.
   function automatic logic [21:0] clamp_tmr(input logic [15:0] v,
                                             input logic units);
      logic [25:0] t;
      t = units ? 26'(v) * 26'(TICKS_PER_MIN) : 26'(v);
      if (t > 26'(TMR_MAX)) begin
         clamp_tmr = TMR_MAX;
      end else if (t < 26'(TMR_MIN)) begin
         clamp_tmr = TMR_MIN;
      end else begin
         clamp_tmr = t[21:0];
      end
   endfunction

   // ****************************************
   // Task file and configuration
   // ****************************************
   logic [7:0] feat_r, cond_id_r, params_r, tmr_lo_r, tmr_hi_r;
   logic [7:0] drv_sel_r;
   logic epc_en_r;
   logic [7:0] sup_r, chg_r, sav_mask_r, view_r;
   state_t state_r;
   logic abt_r, err_r;
   logic [7:0] x_feat_r, x_id_r, x_params_r;
   logic [15:0] x_tmr_r;
   cond_t cur_r [NUM_COND];
   cond_t sav_r [NUM_COND];

   logic wr_ok;
   assign wr_ok = req.wr && state_r == ST_IDLE;

   logic cmd_wr;
   assign cmd_wr = wr_ok && req.addr == OFS_CMD_STAT;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         feat_r <= 8'h00;
         cond_id_r <= 8'h00;
         params_r <= 8'h00;
         tmr_lo_r <= 8'h00;
         tmr_hi_r <= 8'h00;
         drv_sel_r <= 8'h00;
      end else if (wr_ok) begin
         unique case (req.addr)
            OFS_FEAT_ERR: feat_r <= req.wdata[7:0];
            OFS_COND_ID: cond_id_r <= req.wdata[7:0];
            OFS_PARAMS: params_r <= req.wdata[7:0];
            OFS_TMR_LO: tmr_lo_r <= req.wdata[7:0];
            OFS_TMR_HI: tmr_hi_r <= req.wdata[7:0];
            OFS_DRV_SEL: drv_sel_r <= req.wdata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         epc_en_r <= EPC_EN_RST;
         sup_r <= MASK_RST;
         chg_r <= MASK_RST;
         sav_mask_r <= MASK_RST;
         view_r <= 8'h00;
      end else if (req.wr) begin
         unique case (req.addr)
            OFS_EPC_CTRL: epc_en_r <= req.wdata[0];
            OFS_SUP_MASK: sup_r <= req.wdata[7:0];
            OFS_CHG_MASK: chg_r <= req.wdata[7:0];
            OFS_SAV_MASK: sav_mask_r <= req.wdata[7:0];
            OFS_VIEW_SEL: view_r <= req.wdata[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Command capture and decision
   // ****************************************
   // The task file is copied at launch so that the decision sees one
   // consistent set of fields.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         x_feat_r <= 8'h00;
         x_id_r <= 8'h00;
         x_params_r <= 8'h00;
         x_tmr_r <= 16'h0000;
      end else if (cmd_wr) begin
         x_feat_r <= (req.wdata[7:0] == OPC_SET_FEAT) ? feat_r : 8'h00;
         x_id_r <= cond_id_r;
         x_params_r <= params_r;
         x_tmr_r <= {tmr_hi_r, tmr_lo_r};
      end
   end

   logic [IDX_W-1:0] idx;
   logic id_ok, is_timer, is_state, do_save, abort_c;
   logic [21:0] new_tmr;
   logic new_en;

   assign idx = x_id_r[IDX_W-1:0];
   assign is_timer = x_params_r[3:0] == SUB_TIMER;
   assign is_state = x_params_r[3:0] == SUB_STATE;
   assign do_save = x_params_r[PRM_SAVE];
   assign new_tmr = clamp_tmr(x_tmr_r, x_params_r[PRM_UNITS]);

   always_comb begin
      id_ok = 32'(x_id_r) < NUM_COND;
      abort_c = 1'b0;
      if (x_feat_r != FEAT_EPC || !(is_timer || is_state)) begin
         abort_c = 1'b1;
      end
      if (!epc_en_r) begin
         abort_c = 1'b1;
      end
      if (!id_ok || !sup_r[idx] || !chg_r[idx]) begin
         abort_c = 1'b1;
      end
      if (id_ok && do_save && !sav_mask_r[idx]) begin
         abort_c = 1'b1;
      end
   end

   always_comb begin
      if (is_timer) begin
         new_en = x_params_r[PRM_ENABLE] && new_tmr != 22'h0;
      end else begin
         new_en = x_params_r[PRM_ENABLE];
      end
   end

   // ****************************************
   // Sequencing and status
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: if (cmd_wr) state_r <= ST_EXEC;
            ST_EXEC: state_r <= ST_IDLE;
         endcase
      end
   end

   // A new command clears the old outcome; the outcome is only set one
   // cycle later, so the two never meet in one cycle.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         abt_r <= 1'b0;
         err_r <= 1'b0;
         cmd_done <= 1'b0;
      end else begin
         cmd_done <= state_r == ST_EXEC;
         if (cmd_wr) begin
            abt_r <= 1'b0;
            err_r <= 1'b0;
         end else if (state_r == ST_EXEC) begin
            abt_r <= abort_c;
            err_r <= abort_c;
         end
      end
   end

   // ****************************************
   // Power condition settings
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_COND; i++) begin
            cur_r[i] <= '0;
            sav_r[i] <= '0;
         end
      end else if (state_r == ST_EXEC && !abort_c) begin
         cur_r[idx].en <= new_en;
         if (is_timer) begin
            cur_r[idx].tmr <= new_tmr;
            if (do_save) begin
               sav_r[idx] <= '{en: new_en, tmr: new_tmr};
            end
         end else if (do_save) begin
            sav_r[idx].en <= new_en;
         end
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   logic [7:0] status_c;
   logic [IDX_W-1:0] vidx;
   assign vidx = view_r[IDX_W-1:0];
   always_comb begin
      status_c = 8'h00;
      status_c[ST_BSY] = state_r == ST_EXEC;
      status_c[ST_RDY] = state_r == ST_IDLE;
      status_c[ST_DF] = 1'b0;
      status_c[ST_ERR] = err_r;
   end

   always_ff @(posedge ref_clk) begin
      if (rst || !req.rd) begin
         rdata <= 32'h0;
      end else begin
         unique case (req.addr)
            OFS_FEAT_ERR: rdata <= 32'({abt_r, 2'b00} );
            OFS_COND_ID: rdata <= 32'(cond_id_r);
            OFS_PARAMS: rdata <= 32'(params_r);
            OFS_TMR_LO: rdata <= 32'(tmr_lo_r);
            OFS_TMR_HI: rdata <= 32'(tmr_hi_r);
            OFS_DRV_SEL: rdata <= 32'(drv_sel_r);
            OFS_CMD_STAT: rdata <= 32'(status_c);
            OFS_EPC_CTRL: rdata <= 32'(epc_en_r);
            OFS_SUP_MASK: rdata <= 32'(sup_r);
            OFS_CHG_MASK: rdata <= 32'(chg_r);
            OFS_SAV_MASK: rdata <= 32'(sav_mask_r);
            OFS_VIEW_SEL: rdata <= 32'(view_r);
            OFS_VIEW_CUR: rdata <= 32'(cur_r[vidx]);
            OFS_VIEW_SAV: rdata <= 32'(sav_r[vidx]);
            default: rdata <= 32'h0;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   logic exec_ok, exec_ab;
   assign exec_ok = state_r == ST_EXEC && !abort_c;
   assign exec_ab = state_r == ST_EXEC && abort_c;

   abort_keeps_a: assert property (exec_ab |=> $stable(cur_r[idx])
      && $stable(sav_r[idx])) else $error("Abort changed settings.");
   timer_load_a: assert property (exec_ok && is_timer
      |=> cur_r[$past(idx)].tmr == $past(new_tmr))
      else $error("Timer not loaded.");
   timer_enable_a: assert property (exec_ok && is_timer |=>
      cur_r[$past(idx)].en == ($past(x_params_r[PRM_ENABLE])
      && $past(new_tmr) != 22'h0)) else $error("Timer enable wrong.");
   timer_save_a: assert property (exec_ok && is_timer && do_save
      |=> sav_r[$past(idx)] == cur_r[$past(idx)])
      else $error("Saved copy wrong.");
   state_en_a: assert property (exec_ok && is_state |=>
      cur_r[$past(idx)].en == $past(x_params_r[PRM_ENABLE]))
      else $error("State enable wrong.");
   state_save_a: assert property (exec_ok && is_state
      |=> $stable(cur_r[idx].tmr)
      && $stable(sav_r[idx].tmr)) else $error("Timer touched.");
   feature_off_a: assert property (state_r == ST_EXEC && !epc_en_r
      |-> abort_c) else $error("Disabled feature not aborted.");
   clamp_max_a: assert property (state_r == ST_EXEC
      && (x_params_r[PRM_UNITS] ? 32'(x_tmr_r) * 32'(TICKS_PER_MIN)
      : 32'(x_tmr_r)) > 32'(TMR_MAX) |-> new_tmr == TMR_MAX)
      else $error("Timer above maximum not clamped.");
   abort_stat_a: assert property (exec_ab |=> abt_r && err_r
      && state_r == ST_IDLE) else $error("Abort status wrong.");
   ok_stat_a: assert property (cmd_wr ##1 !abort_c |=> !abt_r
      && !err_r && status_c[ST_RDY]) else $error("Success status wrong.");

   timer_ok_c: cover property (exec_ok && is_timer && do_save);
   state_ok_c: cover property (exec_ok && is_state);
   clamp_c: cover property (exec_ok && is_timer && new_tmr == TMR_MAX);
   abort_c_c: cover property (exec_ab);

endmodule
`default_nettype wire

// *** task_file_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module task_file_host (
   input wire logic ref_clk,
   input wire logic [31:0] rdata,
   output var epc_pkg::reg_req_t req
);
   import epc_pkg::*;

   int gap = 0;

   initial req = '0;

   // ****************************************
   // Bus cycles
   // ****************************************
   // A write holds its strobe across the taking edge; back-to-back writes
   // keep it up, so a slow host only idles between registers, never on the
   // command write, whose completion pulse the caller must not miss.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      req.addr <= a;
      req.wdata <= {24'h000000, d};
      req.wr <= 1'b1;
      req.rd <= 1'b0;
      @(posedge ref_clk);
      if (gap > 0 && a != OFS_CMD_STAT) begin
         req.wr <= 1'b0;
         repeat (gap) @(posedge ref_clk);
      end
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      req.addr <= a;
      req.rd <= 1'b1;
      req.wr <= 1'b0;
      @(posedge ref_clk);
      req.rd <= 1'b0;
      @(negedge ref_clk);
      d = rdata;
      @(posedge ref_clk);
   endtask

   task automatic idle();
      req.wr <= 1'b0;
      req.rd <= 1'b0;
   endtask

   // ****************************************
   // Command issue
   // ****************************************
   task automatic issue(input logic [7:0] cond, prm, feat,
         input logic [15:0] tmr);
      wr(OFS_FEAT_ERR, feat);
      wr(OFS_COND_ID, cond);
      wr(OFS_PARAMS, prm);
      wr(OFS_TMR_LO, tmr[7:0]);
      wr(OFS_TMR_HI, tmr[15:8]);
      wr(OFS_CMD_STAT, OPC_SET_FEAT);
   endtask
endmodule
`default_nettype wire

// *** tb_power_condition_timer_state_cmd.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_power_condition_timer_state_cmd;
   import epc_pkg::*;

   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   epc_pkg::reg_req_t req;
   logic [31:0] rdata;
   logic cmd_done;
   logic [31:0] v;
   logic [7:0] fv = FEAT_EPC;
   int n_fail = 0;
   int n_compared = 0;
   logic [3:0] ofs [7] = '{OFS_CMD_STAT, OFS_FEAT_ERR, OFS_EPC_CTRL,
      OFS_SUP_MASK, OFS_CHG_MASK, OFS_SAV_MASK, 4'he};
   logic [31:0] rv [7] = '{32'h40, 32'h0, 32'h1, 32'hff, 32'hff, 32'hff,
      32'h0};
   logic [3:0] ao [10] = '{OFS_SUP_MASK, OFS_CHG_MASK, OFS_SAV_MASK,
      OFS_EPC_CTRL, OFS_EPC_CTRL, OFS_SAV_MASK, OFS_CHG_MASK, OFS_SUP_MASK,
      OFS_SUP_MASK, OFS_SUP_MASK};
   logic [7:0] av [10] = '{8'hfd, 8'hfd, 8'hfd, 8'h00, 8'h00, 8'hfd, 8'hfd,
      8'hff, 8'hff, 8'hff};
   logic [7:0] ac [10] = '{8'h1, 8'h1, 8'h1, 8'h1, 8'h1, 8'h1, 8'h1, 8'h8,
      8'hff, 8'h1};
   logic [7:0] ap [10] = '{8'h32, 8'h32, 8'h32, 8'h32, 8'h33, 8'h33, 8'h33,
      8'h32, 8'h32, 8'h35};

   always #12.5 ref_clk = ~ref_clk;

   epc_cmd #(.NUM_COND(8)) u_dut (.ref_clk(ref_clk), .rst(rst), .req(req),
      .rdata(rdata), .cmd_done(cmd_done));
   task_file_host u_host (.ref_clk(ref_clk), .rdata(rdata), .req(req));

   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen,
            exp);
      end
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
         input string what);
      u_host.rd(a, v);
      check(v, exp, what);
   endtask

   // Issues one subcommand, then checks the outcome and the settings of
   // condition vc through the view registers.
   task automatic run(input logic [7:0] cond, prm, input logic [15:0] tmr,
         input logic abt, input logic [7:0] vc, input logic [31:0] cur, sav);
      int i;
      u_host.issue(cond, prm, fv, tmr);
      u_host.idle();
      for (i = 0; i < 8; i++) begin
         @(negedge ref_clk);
         if (cmd_done === 1'b1) break;
      end
      if (i == 8) begin
         n_fail++;
         $display("[FAIL] %0t completion pulse missing", $time);
         wrap_up();
      end
      check(i, 1, "completion delay");
      @(posedge ref_clk);
      rd_chk(OFS_CMD_STAT, abt ? 32'h41 : 32'h40, "status");
      rd_chk(OFS_FEAT_ERR, abt ? 32'h4 : 32'h0, "error");
      u_host.wr(OFS_VIEW_SEL, vc);
      rd_chk(OFS_VIEW_CUR, cur, "current");
      rd_chk(OFS_VIEW_SAV, sav, "saved");
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      foreach (ofs[k]) rd_chk(ofs[k], rv[k], "reset value");
      $display("Test done: reset values");
      run(8'h1, 8'h32, 16'h1234, 1'b0, 8'h1, 32'h401234, 32'h401234);
      run(8'h2, 8'ha2, 16'h0002, 1'b0, 8'h2, 32'h4004b0, 32'h0);
      run(8'h3, 8'hb2, 16'hffff, 1'b0, 8'h3, 32'h7bffc4, 32'h7bffc4);
      run(8'h4, 8'h32, 16'h0000, 1'b0, 8'h4, 32'h0, 32'h0);
      u_host.gap = 2;
      run(8'h5, 8'h12, 16'h0055, 1'b0, 8'h5, 32'h55, 32'h55);
      u_host.gap = 0;
      run(8'h2, 8'h33, 16'h0000, 1'b0, 8'h2, 32'h4004b0, 32'h400000);
      run(8'h1, 8'h03, 16'h0000, 1'b0, 8'h1, 32'h1234, 32'h401234);
      u_host.wr(OFS_SAV_MASK, 8'hfd);
      run(8'h1, 8'h22, 16'h0010, 1'b0, 8'h1, 32'h400010, 32'h401234);
      u_host.wr(OFS_SAV_MASK, 8'hff);
      $display("Test done: successful subcommands");
      for (int k = 0; k < 10; k++) begin
         u_host.wr(ao[k], av[k]);
         // Every entry must abort and leave condition 1 as it was.
         run(ac[k], ap[k], 16'h0777, 1'b1, 8'h1, 32'h400010,
            32'h401234);
         u_host.wr(ao[k], (ao[k] == OFS_EPC_CTRL) ? 8'h01 : 8'hff);
      end
      run(8'h1, 8'h2f, 16'h0777, 1'b1, 8'h1, 32'h400010, 32'h401234);
      // A feature code other than the power condition one must abort.
      fv = 8'h4b;
      run(8'h1, 8'h32, 16'h0777, 1'b1, 8'h1, 32'h400010, 32'h401234);
      fv = FEAT_EPC;
      $display("Test done: aborted subcommands");
      u_host.issue(8'h1, 8'h22, FEAT_EPC, 16'h0010);
      u_host.wr(OFS_COND_ID, 8'h05);
      u_host.idle();
      repeat (3) @(posedge ref_clk);
      rd_chk(OFS_COND_ID, 32'h1, "write while busy");
      $display("Test done: write while busy");
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      $display("[FAIL] %0t run did not finish", $time);
      wrap_up();
   end
endmodule
`default_nettype wire
